// [rtl/sla_align.sv]
`timescale 1ns/10ps
`include "sla_regs.svh"
module sla_align (
	input wire logic clk,
	input wire logic sys_rst,
	input wire sla_pkg::sla_avl_req_t avl_req,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic ref_in,
	output logic [1:0] link_sync_request_out,
	output logic [1:0] lmfc_strobe,
	output logic datapath_ramp,
	output logic ref_bias_en,
	output logic ref_jitter_event
);
	import sla_pkg::*;

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [7:0] ref_edge_skip_count;
	logic [7:0] ref_jitter_window;
	logic [7:0] align_sync_enable;
	logic [7:0] lmfc_period;
	logic [7:0] coupling_reg;
	logic [7:0] subclass_reg;
	logic align_arm_once;
	logic align_done;
	logic jitter_flag;

	sla_state_t state;
	sla_state_t next_state;
	logic [7:0] skip_left;
	logic [7:0] next_skip_left;
	logic [7:0] lmfc_cnt;
	logic [7:0] next_lmfc_cnt;
	logic ack;
	logic [31:0] rd_q;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire req = avl_req.read | avl_req.write;
	wire wr_go = avl_req.write & ack & avl_req.byteenable[0];
	wire [7:0] wdat = avl_req.writedata[7:0];
	wire hit_skip = avl_req.address == `SLA_IDX_SKIP;
	wire hit_window = avl_req.address == `SLA_IDX_WINDOW;
	wire hit_control = avl_req.address == `SLA_IDX_CONTROL;
	wire hit_enable = avl_req.address == `SLA_IDX_ENABLE;
	wire hit_period = avl_req.address == `SLA_IDX_PERIOD;
	wire hit_status = avl_req.address == `SLA_IDX_STATUS;
	wire hit_coupling = avl_req.address == `SLA_IDX_COUPLING;
	wire hit_subclass = avl_req.address == `SLA_IDX_SUBCLASS;

	wire wr_skip = wr_go & hit_skip;
	wire wr_window = wr_go & hit_window;
	wire wr_control = wr_go & hit_control;
	wire wr_enable = wr_go & hit_enable;
	wire wr_period = wr_go & hit_period;
	wire wr_status = wr_go & hit_status;
	wire wr_coupling = wr_go & hit_coupling;
	wire wr_subclass = wr_go & hit_subclass;

	// A request is held for exactly one wait cycle, then acknowledged.
	assign waitrequest = req & ~ack;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	// ------------------------------------------------------------
	// Plain configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_edge_skip_count <= `SLA_RST_SKIP;
			ref_jitter_window <= `SLA_RST_WINDOW;
			align_sync_enable <= `SLA_RST_ENABLE;
			lmfc_period <= `SLA_RST_PERIOD;
			coupling_reg <= `SLA_RST_COUPLING;
			subclass_reg <= `SLA_RST_SUBCLASS;
		end else begin
			if (wr_skip) begin
				ref_edge_skip_count <= wdat;
			end
			if (wr_window) begin
				ref_jitter_window <= wdat;
			end
			if (wr_enable) begin
				align_sync_enable <= wdat;
			end
			if (wr_period) begin
				lmfc_period <= wdat;
			end
			if (wr_coupling) begin
				coupling_reg <= wdat;
			end
			if (wr_subclass) begin
				subclass_reg <= wdat;
			end
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire [2:0] subclass = subclass_reg[`SLA_SUB_LSB +: 3];
	wire sub1 = subclass == 3'h1;
	wire sync_on = align_sync_enable[`SLA_EN_SYNC];
	wire soft_on = align_sync_enable[`SLA_EN_SOFT];
	wire [7:0] last_phase = lmfc_period - 8'h01;

	// An arming request is a write that takes the arm bit from 0 to 1 while the sync enable bit is set.
	wire arm_wr = wr_control & wdat[`SLA_CTL_ARM];
	wire arm_new = arm_wr & ~align_arm_once & sync_on;
	wire disarm = wr_control & ~wdat[`SLA_CTL_ARM];

	// ------------------------------------------------------------
	// SYSREF capture
	// ------------------------------------------------------------
	logic ref_rise;

	sla_edge_detect u_edge (
		.clk(clk),
		.sys_rst(sys_rst),
		.ref_in(ref_in),
		.rise(ref_rise)
	);

	// ------------------------------------------------------------
	// Alignment sequencer
	// ------------------------------------------------------------
	// internal edge in subclass 0
	wire align_edge = sub1 ? ref_rise : 1'b1;
	wire skip_done = skip_left == 8'h00;
	wire armed = state == SLA_ARMED;
	wire align_now = armed & align_edge & (skip_done | ~sub1);

	always_comb begin
		next_state = state;
		next_skip_left = skip_left;
		unique case (state)
			SLA_IDLE: begin
				if (arm_new) begin
					next_state = SLA_ARMED;
					next_skip_left = ref_edge_skip_count;
				end
			end
			SLA_ARMED: begin
				if (disarm) begin
					next_state = SLA_IDLE;
				end else if (align_now) begin
					next_state = SLA_ALIGNED;
				end else if (sub1 & ref_rise) begin
					next_skip_left = skip_left - 8'h01;
				end
			end
			SLA_ALIGNED: begin
				if (arm_new) begin
					next_state = SLA_ARMED;
					next_skip_left = ref_edge_skip_count;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= SLA_IDLE;
			skip_left <= 8'h00;
		end else begin
			state <= next_state;
			skip_left <= next_skip_left;
		end
	end

	// ------------------------------------------------------------
	// Arm bit and done flag
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			align_arm_once <= 1'b0;
		end else if (wr_control) begin
			align_arm_once <= wdat[`SLA_CTL_ARM];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			align_done <= 1'b0;
		end else if (align_now) begin
			align_done <= 1'b1;
		end else if (arm_new) begin
			align_done <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Local multiframe counter
	// ------------------------------------------------------------
	wire lmfc_wrap = lmfc_cnt >= last_phase;

	always_comb begin
		if (align_now) begin
			next_lmfc_cnt = 8'h01;
		end else if (lmfc_wrap) begin
			next_lmfc_cnt = 8'h00;
		end else begin
			next_lmfc_cnt = lmfc_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lmfc_cnt <= 8'h00;
		end else begin
			lmfc_cnt <= next_lmfc_cnt;
		end
	end

	logic lmfc_tick;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lmfc_tick <= 1'b0;
		end else begin
			// The strobe trails every phase-zero cycle by one clock.
			lmfc_tick <= align_now | (lmfc_cnt == 8'h00);
		end
	end

	assign lmfc_strobe = {2{lmfc_tick}};

	// ------------------------------------------------------------
	// Jitter monitor
	// ------------------------------------------------------------
	sla_jit_cfg_t jit_cfg;
	logic outside;

	assign jit_cfg.period = lmfc_period;
	assign jit_cfg.window_q = ref_jitter_window[5:2];

	sla_jitter_check u_jit (
		.cfg(jit_cfg),
		.phase(lmfc_cnt),
		.outside(outside)
	);

	wire jit_set = (state == SLA_ALIGNED) & sub1 & ref_rise & outside;
	wire jit_clr = wr_status & wdat[`SLA_STS_JITTER];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			jitter_flag <= 1'b0;
		end else begin
			jitter_flag <= jit_set | (jitter_flag & ~jit_clr);
		end
	end

	assign ref_jitter_event = jitter_flag;

	// ------------------------------------------------------------
	// Link and datapath outputs
	// ------------------------------------------------------------
	logic link_up;
	logic ramp;
	logic bias;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			link_up <= 1'b0;
			ramp <= 1'b0;
			bias <= 1'b1;
		end else begin
			link_up <= (next_state == SLA_ALIGNED);
			ramp <= soft_on & (next_state == SLA_ARMED);
			bias <= ~coupling_reg[`SLA_COUPLING_DC];
		end
	end

	assign link_sync_request_out = {2{link_up}};
	assign datapath_ramp = ramp;
	assign ref_bias_en = bias;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [7:0] ctl_view;
	logic [7:0] sts_view;
	logic [7:0] rd_sel;

	always_comb begin
		ctl_view = 8'h00;
		ctl_view[`SLA_CTL_ARM] = align_arm_once;
		ctl_view[`SLA_CTL_DONE] = align_done;
		sts_view = 8'h00;
		sts_view[`SLA_STS_JITTER] = jitter_flag;
		sts_view[`SLA_STS_ALIGNED] = state == SLA_ALIGNED;
	end

	always_comb begin
		rd_sel = 8'h00;
		if (hit_skip) begin
			rd_sel = ref_edge_skip_count;
		end else if (hit_window) begin
			rd_sel = ref_jitter_window;
		end else if (hit_control) begin
			rd_sel = ctl_view;
		end else if (hit_enable) begin
			rd_sel = align_sync_enable;
		end else if (hit_period) begin
			rd_sel = lmfc_period;
		end else if (hit_status) begin
			rd_sel = sts_view;
		end else if (hit_coupling) begin
			rd_sel = coupling_reg;
		end else if (hit_subclass) begin
			rd_sel = subclass_reg;
		end
	end

	// Read data is loaded in the wait cycle so it stands at the ack edge.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_q <= 32'h0000_0000;
		end else if (avl_req.read & ~ack) begin
			rd_q <= {24'h00_0000, rd_sel};
		end
	end

	assign readdata = rd_q;

endmodule // sla_align

// [rtl/sla_edge_detect.sv]
`timescale 1ns/10ps
module sla_edge_detect (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ref_in,
	output logic rise
);
	import sla_pkg::*;

	logic meta;
	logic sync;
	logic last;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= ref_in;
			sync <= meta;
			last <= sync;
		end
	end

	assign rise = sync & ~last;

endmodule // sla_edge_detect

// [rtl/sla_jitter_check.sv]
`timescale 1ns/10ps
module sla_jitter_check (
	input wire sla_pkg::sla_jit_cfg_t cfg,
	input wire logic [7:0] phase,
	output logic outside
);
	import sla_pkg::*;

	logic [7:0] mirror;
	logic [7:0] dev;
	logic early_half;

	// The distance to the nearest LMFC boundary, in sample clocks.
	assign mirror = cfg.period - phase;
	assign early_half = phase <= {1'b0, cfg.period[7:1]};
	assign dev = early_half ? phase : mirror;

	assign outside = dev > {4'h0, cfg.window_q};

endmodule // sla_jitter_check

// [shared/sla_pkg.sv]
package sla_pkg;

	typedef enum logic [1:0] {
		SLA_IDLE,
		SLA_ARMED,
		SLA_ALIGNED
	} sla_state_t;

	typedef struct packed {
		logic [11:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} sla_avl_req_t;

	typedef struct packed {
		logic [7:0] period;
		logic [3:0] window_q;
	} sla_jit_cfg_t;

endpackage

// [shared/sla_regs.svh]
`ifndef SLA_REGS_SVH
`define SLA_REGS_SVH

`define SLA_IDX_SKIP 12'h036
`define SLA_IDX_WINDOW 12'h039
`define SLA_IDX_CONTROL 12'h03a
`define SLA_IDX_ENABLE 12'h03b
`define SLA_IDX_PERIOD 12'h03c
`define SLA_IDX_STATUS 12'h03d
`define SLA_IDX_COUPLING 12'h084
`define SLA_IDX_SUBCLASS 12'h458

`define SLA_CTL_ARM 1
`define SLA_CTL_DONE 4
`define SLA_EN_SYNC 0
`define SLA_EN_SOFT 1
`define SLA_STS_JITTER 0
`define SLA_STS_ALIGNED 1
`define SLA_COUPLING_DC 6
`define SLA_SUB_LSB 5

`define SLA_RST_SKIP 8'h00
`define SLA_RST_WINDOW 8'h04
`define SLA_RST_ENABLE 8'h00
`define SLA_RST_PERIOD 8'h10
`define SLA_RST_COUPLING 8'h00
`define SLA_RST_SUBCLASS 8'h20

`define SLA_DAC_PER_SAMPLE 4

`endif

// [verification/sla_align_checker.sv]
`timescale 1ns/10ps
module sla_align_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire sla_pkg::sla_avl_req_t avl_req,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic ref_in,
	input wire logic [1:0] link_sync_request_out,
	input wire logic [1:0] lmfc_strobe,
	input wire logic datapath_ramp,
	input wire logic ref_bias_en,
	input wire logic ref_jitter_event
);
	import sla_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire wr_ok;
	wire clr_ok;
	logic [3:0] since;
	assign wr_ok = avl_req.write & ~waitrequest & avl_req.byteenable[0];
	assign clr_ok = wr_ok & (avl_req.address == 12'h03d)
		& avl_req.writedata[0];
	// Counts cycles since the reference pin was last seen high.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) since <= 4'hf;
		else since <= ref_in ? 4'h0 : (since == 4'hf ? since : since + 4'h1);
	end
	sequence s_req;
		(avl_req.read || avl_req.write) && waitrequest;
	endsequence
	sequence s_aligned;
		$rose(link_sync_request_out[0]);
	endsequence
	property p_bias;
		(wr_ok && avl_req.address == 12'h084)
			|-> ##2 ref_bias_en == !$past(avl_req.writedata[6], 2);
	endproperty
	AST_WAIT_ONE: assert property (s_req |=> !waitrequest)
		else $error("waitrequest held beyond one cycle");
	AST_STROBE_PAIR: assert property (lmfc_strobe[0] == lmfc_strobe[1])
		else $error("channel strobes differ");
	AST_LINK_PAIR: assert property (
		link_sync_request_out[0] == link_sync_request_out[1])
		else $error("link requests differ");
	AST_JIT_STICKY: assert property (
		ref_jitter_event && !clr_ok |=> ref_jitter_event)
		else $error("jitter flag dropped without clear");
	AST_ALIGN_STROBE: assert property (s_aligned |-> lmfc_strobe[0])
		else $error("links rose without alignment strobe");
	AST_BIAS: assert property (p_bias)
		else $error("bias enable does not follow coupling bit");
	AST_JIT_EDGE: assert property ($rose(ref_jitter_event) |-> since <= 4'h8)
		else $error("jitter flag without a reference edge");
	AST_JIT_ALIGNED: assert property (
		$rose(ref_jitter_event) |-> link_sync_request_out[0])
		else $error("jitter flag outside aligned state");
endmodule // sla_align_checker
bind sla_align sla_align_checker i_chk (.clk, .sys_rst, .avl_req, .readdata,
	.waitrequest, .ref_in, .link_sync_request_out, .lmfc_strobe,
	.datapath_ramp, .ref_bias_en, .ref_jitter_event);

// [verification/sla_ref_source.sv]
`timescale 1ns/10ps
module sla_ref_source (
	input wire logic clk,
	output logic ref_in
);
	initial ref_in = 1'b0;
	task automatic send(input int lead, input int count, input int period,
		input int width);
		int w;
		w = width < 2 ? 2 : width;
		repeat (lead) @(posedge clk);
		repeat (count) begin
			ref_in <= 1'b1;
			repeat (w) @(posedge clk);
			ref_in <= 1'b0;
			repeat (period - w) @(posedge clk);
		end
	endtask
endmodule // sla_ref_source

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
	import sla_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	sla_avl_req_t req = '0;
	logic [31:0] readdata;
	logic waitrequest;
	logic ref_in;
	logic [1:0] link;
	logic [1:0] strobe;
	logic ramp;
	logic bias;
	logic jit;
	logic [7:0] q;
	int err_count = 0;
	int samples_checked = 0;
	always #2 clk = ~clk;
	sla_align i_dut (.clk(clk), .sys_rst(sys_rst), .avl_req(req),
		.readdata(readdata), .waitrequest(waitrequest), .ref_in(ref_in),
		.link_sync_request_out(link), .lmfc_strobe(strobe),
		.datapath_ramp(ramp), .ref_bias_en(bias), .ref_jitter_event(jit));
	sla_ref_source i_ref (.clk(clk), .ref_in(ref_in));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clk);
		req.address <= a;
		req.read <= ~wr;
		req.write <= wr;
		req.byteenable <= 4'h1;
		req.writedata <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0) begin
			err_count++;
			print_verdict();
		end
		q = readdata[7:0];
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		bus(1'b0, a, 8'h00);
		check(q & m, e);
	endtask
	task automatic wait_link(input logic [1:0] e);
		for (int n = 0; n < 200 && link !== e; n++) @(negedge clk);
		check(link, e);
		if (link !== e) begin
			print_verdict();
		end
	endtask
	task automatic test_regs();
		logic [11:0] idx [8] = '{12'h036, 12'h039, 12'h03a, 12'h03b,
			12'h03c, 12'h03d, 12'h084, 12'h458};
		logic [7:0] rv [8] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h10, 8'h00,
			8'h00, 8'h20};
		check({bias, link}, 3'b100);
		for (int i = 0; i < 8; i++) rd(idx[i], rv[i]);
		wr(12'h100, 8'h5a);
		rd(12'h100, 8'h00);
		wr(12'h084, 8'h40);
		rd(12'h084, 8'h40);
		check(bias, 1'b0);
		wr(12'h084, 8'h00);
		rd(12'h084, 8'h00);
		check(bias, 1'b1);
		$display("test_regs done");
	endtask
	task automatic test_sub0();
		int n;
		wr(12'h458, 8'h00);
		wr(12'h03a, 8'h02);
		rd(12'h03a, 8'h00, 8'h10);
		check(link, 2'b00);
		wr(12'h03a, 8'h00);
		wr(12'h03b, 8'hf1);
		wr(12'h03a, 8'h02);
		wait_link(2'b11);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (strobe !== 2'b11 && n < 40);
		check(n, 32'h10);
		if (strobe !== 2'b11) begin
			print_verdict();
		end
		rd(12'h03a, 8'h12);
		check(ramp, 1'b0);
		$display("test_sub0 done");
	endtask
	task automatic test_sub1();
		wr(12'h458, 8'h20);
		wr(12'h039, 8'h0b);
		wr(12'h036, 8'h03);
		wr(12'h03b, 8'hf3);
		wr(12'h03a, 8'h00);
		wr(12'h03a, 8'h02);
		repeat (2) @(negedge clk);
		check({ramp, link}, 3'b100);
		rd(12'h03a, 8'h00, 8'h10);
		i_ref.send(0, 3, 24, 8);
		check(link, 2'b00);
		i_ref.send(0, 5, 16, 2);
		check({ramp, link, jit}, 4'b0110);
		i_ref.send(2, 1, 16, 2);
		check(jit, 1'b0);
		i_ref.send(1, 1, 16, 2);
		check(jit, 1'b1);
		rd(12'h03d, 8'h03);
		wr(12'h03d, 8'h01);
		rd(12'h03d, 8'h02);
		check(jit, 1'b0);
		$display("test_sub1 done");
	endtask
	task automatic test_realign();
		wr(12'h03a, 8'h00);
		wr(12'h03a, 8'h02);
		rd(12'h03a, 8'h00, 8'h10);
		check(link, 2'b00);
		wr(12'h03a, 8'h00);
		rd(12'h03a, 8'h00, 8'h10);
		check(link, 2'b00);
		wr(12'h458, 8'h40);
		wr(12'h03a, 8'h02);
		wait_link(2'b11);
		rd(12'h03a, 8'h10, 8'h10);
		$display("test_realign done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		test_regs();
		test_sub0();
		test_sub1();
		test_realign();
		print_verdict();
	end
endmodule // tb
